// ### design/vec_misc_alu.sv
`timescale 1ns/1ps
module vec_misc_alu #(
	parameter logic [vec_misc_pkg::PI_BITS-1:0] PI_TABLE =
		{128'hA2F9836E4E441529FC2757D1F534DDC0, 1073'h0}
) (
	input  wire logic                   clock,  // Core clock
	input  wire logic                   rstn,   // Synchronous reset, low
	input  wire vec_misc_pkg::alu_req_s req,    // Issued instruction
	output vec_misc_pkg::alu_resp_s     resp_r  // Registered result
);

	// ****************************************
	// Opcode decode
	// ****************************************

	wire [9:0] op       = req.opcode;
	wire       is_trig  = (op == vec_misc_pkg::OP_TRIG);
	wire       is_bfm   = (op == vec_misc_pkg::OP_BFM);
	wire       is_sn32  = (op == vec_misc_pkg::OP_SN32);
	wire       is_un32  = (op == vec_misc_pkg::OP_UN32);
	wire       is_rtz   = (op == vec_misc_pkg::OP_RTZ);
	wire       is_pku   = (op == vec_misc_pkg::OP_PKU);
	wire       is_pks   = (op == vec_misc_pkg::OP_PKS);
	wire       is_sn16  = (op == vec_misc_pkg::OP_SN16);
	wire       is_un16  = (op == vec_misc_pkg::OP_UN16);
	wire       is_add32 = (op == vec_misc_pkg::OP_ADD32);
	wire       is_sub32 = (op == vec_misc_pkg::OP_SUB32);
	wire       is_add16 = (op == vec_misc_pkg::OP_ADD16);
	wire       is_sub16 = (op == vec_misc_pkg::OP_SUB16);
	wire       is_packh = (op == vec_misc_pkg::OP_PACKH);
	wire       known    = is_trig | is_bfm | is_sn32 | is_un32 | is_rtz
		| is_pku | is_pks | is_sn16 | is_un16 | is_add32 | is_sub32
		| is_add16 | is_sub16 | is_packh;

	// ****************************************
	// Segment lookup of the constant 2/pi
	// ****************************************

	logic [63:0] trig_res;

	// Segment select is operand one bits 4:0
	two_over_pi_lookup #(
		.TABLE (PI_TABLE)
	) u_lookup (
		.src0   (req.src0),
		.sel    (req.src1[4:0]),
		.result (trig_res)
	);

	// ****************************************
	// Bitfield mask
	// ****************************************

	// Run of ones of given width, moved up by the offset
	wire [31:0] ones     = (32'h00000001 << req.src0[4:0]) - 32'h00000001;
	wire [31:0] bfm_mask = ones << req.src1[4:0];

	// ****************************************
	// Per-operand conversions
	// ****************************************

	wire [1:0][31:0] opnd = {req.src1[31:0], req.src0[31:0]};
	logic [1:0][15:0] sn32;
	logic [1:0][15:0] un32;
	logic [1:0][15:0] sn16;
	logic [1:0][15:0] un16;
	logic [1:0][15:0] h16;
	logic [1:0][15:0] pku;
	logic [1:0][15:0] pks;

	// Lane j of every pack comes from operand j; j=1 is the upper half
	for (genvar j = 0; j < 2; j++) begin : g_opnd
		norm16_convert #(
			.EXP_W (8),
			.MAN_W (23)
		) u_n32 (
			.val   (opnd[j]),
			.snorm (sn32[j]),
			.unorm (un32[j])
		);

		norm16_convert #(
			.EXP_W (5),
			.MAN_W (10)
		) u_n16 (
			.val   (opnd[j][15:0]),
			.snorm (sn16[j]),
			.unorm (un16[j])
		);

		wire               fs   = opnd[j][31];
		wire [7:0]         fe   = opnd[j][30:23];
		wire [22:0]        fm   = opnd[j][22:0];
		wire signed [9:0]  he   = $signed({2'b00, fe}) - vec_misc_pkg::H_ADJ;
		wire [9:0]         hsh  = 10'(10'sh001 - he);
		wire [10:0]        hsub = {1'b1, fm[22:13]} >> hsh;

		// Single to half, dropped bits discarded; overflow gives max finite
		assign h16[j] = (&fe) ?
			{fs, ((|fm) ? vec_misc_pkg::H_QNAN : vec_misc_pkg::H_INF)} :
			(he >= 10'sh01F) ? {fs, vec_misc_pkg::H_MAXF} :
			(he >= 10'sh001) ? {fs, he[4:0], fm[22:13]} :
			{fs, 5'h00, hsub[9:0]};

		// Integer narrowing with clamping to the 16-bit range
		assign pku[j] = (|opnd[j][31:16]) ? vec_misc_pkg::UNORM_MAX : opnd[j][15:0];
		assign pks[j] = ((&opnd[j][31:15]) || !(|opnd[j][31:15])) ? opnd[j][15:0] :
			(opnd[j][31] ? vec_misc_pkg::S16_MIN : vec_misc_pkg::S16_MAX);
	end

	// ****************************************
	// Signed add and subtract
	// ****************************************

	wire [31:0] a32 = req.src0[31:0];
	wire [31:0] b32 = req.src1[31:0];
	wire [15:0] a16 = req.src0[15:0];
	wire [15:0] b16 = req.src1[15:0];

	// One extra bit catches overflow
	wire [32:0] s33  = {a32[31], a32} + (is_sub32 ? -{b32[31], b32} : {b32[31], b32});
	wire [16:0] s17  = {a16[15], a16} + (is_sub16 ? -{b16[15], b16} : {b16[15], b16});
	wire        ov32 = s33[32] ^ s33[31];
	wire        ov16 = s17[16] ^ s17[15];

	// Saturate only when clamp is set, otherwise wrap
	wire [31:0] r32 = (req.clamp && ov32) ?
		(s33[32] ? vec_misc_pkg::S32_MIN : vec_misc_pkg::S32_MAX) : s33[31:0];
	wire [15:0] r16 = (req.clamp && ov16) ?
		(s17[16] ? vec_misc_pkg::S16_MIN : vec_misc_pkg::S16_MAX) : s17[15:0];

	// ****************************************
	// Result selection
	// ****************************************

	wire [63:0] alu_data =
		is_trig ? trig_res :
		is_bfm ? {32'h0, bfm_mask} :
		is_sn32 ? {32'h0, sn32[1], sn32[0]} :
		is_un32 ? {32'h0, un32[1], un32[0]} :
		is_rtz ? {32'h0, h16[1], h16[0]} :
		is_pku ? {32'h0, pku[1], pku[0]} :
		is_pks ? {32'h0, pks[1], pks[0]} :
		is_sn16 ? {32'h0, sn16[1], sn16[0]} :
		is_un16 ? {32'h0, un16[1], un16[0]} :
		(is_add32 | is_sub32) ? {32'h0, r32} :
		(is_add16 | is_sub16) ? {48'h0, r16} :
		is_packh ? {32'h0, req.src1[15:0], req.src0[15:0]} :
		64'h0;

	vec_misc_pkg::alu_resp_s resp_nxt;

	// Unknown opcodes answer zero with the illegal flag
	assign resp_nxt.valid   = req.valid;
	assign resp_nxt.illegal = req.valid & ~known;
	assign resp_nxt.data    = (req.valid && known) ? alu_data : 64'h0;

	// Result register, one cycle after issue
	always_ff @(posedge clock) begin
		if (!rstn) begin
			resp_r <= vec_misc_pkg::RESP_RST;
		end else begin
			resp_r <= resp_nxt;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	resp_valid_a: assert property (
		1 |=> (resp_r.valid == $past(req.valid)))
		else $error("result valid does not follow issue");

	bfm_width_a: assert property (
		req.valid && is_bfm && ((6'(req.src0[4:0]) + 6'(req.src1[4:0])) <= 6'd32)
		|=> ($countones(resp_r.data[31:0]) == 32'($past(req.src0[4:0]))))
		else $error("bitfield mask has wrong width");

	add_sat_a: assert property (
		req.valid && is_add32 && req.clamp && !a32[31] && !b32[31] && s33[31]
		|=> (resp_r.data[31:0] == vec_misc_pkg::S32_MAX))
		else $error("32-bit add did not saturate high");

	sub_sat_a: assert property (
		req.valid && is_sub32 && req.clamp && a32[31] && !b32[31] && !s33[31]
		|=> (resp_r.data[31:0] == vec_misc_pkg::S32_MIN))
		else $error("32-bit subtract did not saturate low");

	short_sat_a: assert property (
		req.valid && is_add16 && req.clamp && !a16[15] && !b16[15] && s17[15]
		|=> (resp_r.data[15:0] == vec_misc_pkg::S16_MAX))
		else $error("16-bit add did not saturate high");

	add_wrap_a: assert property (
		req.valid && is_add32 && !req.clamp
		|=> (resp_r.data[31:0] == 32'($past(a32) + $past(b32))))
		else $error("32-bit add without clamp did not wrap");

	half_pack_a: assert property (
		req.valid && is_packh
		|=> (resp_r.data[31:0] == {$past(req.src1[15:0]), $past(req.src0[15:0])}))
		else $error("half pack halves misplaced");

	int_pack_a: assert property (
		req.valid && is_pku && !(|req.src0[31:16]) && !(|req.src1[31:16])
		|=> (resp_r.data[31:0] == {$past(req.src1[15:0]), $past(req.src0[15:0])}))
		else $error("integer pack halves misplaced");

	rtz_half_a: assert property (
		req.valid && is_rtz && (req.src0[30:23] == 8'h7F)
		|=> (resp_r.data[15:0] == {$past(req.src0[31]), 5'h0F, $past(req.src0[22:13])}))
		else $error("truncating half conversion wrong");

	snorm_one_a: assert property (
		req.valid && is_sn32 && (req.src0[31:0] == 32'h3F800000)
		|=> (resp_r.data[15:0] == vec_misc_pkg::SNORM_MAX))
		else $error("signed norm of one is not full scale");

	unorm_neg_a: assert property (
		req.valid && is_un16 && req.src1[15]
		|=> (resp_r.data[31:16] == 16'h0000))
		else $error("negative unsigned norm not clamped to zero");

	trig_exp_a: assert property (
		req.valid && is_trig && (req.src1[4:0] == 5'h00) && PI_TABLE[1200]
		&& (req.src0[62:52] <= vec_misc_pkg::EXP_LIM)
		|=> (resp_r.data[63:52] == 12'h3FE))
		else $error("first segment has wrong exponent");

	sub_wrap_a: assert property (
		req.valid && is_sub32 && !req.clamp
		|=> (resp_r.data[31:0] == 32'($past(a32) - $past(b32))))
		else $error("32-bit subtract without clamp did not wrap");

	short_wrap_a: assert property (
		req.valid && is_add16 && !req.clamp
		|=> (resp_r.data[15:0] == 16'($past(a16) + $past(b16))))
		else $error("16-bit add without clamp did not wrap");

	short_sub_sat_a: assert property (
		req.valid && is_sub16 && req.clamp && a16[15] && !b16[15] && !s17[15]
		|=> (resp_r.data[15:0] == vec_misc_pkg::S16_MIN))
		else $error("16-bit subtract did not saturate low");

	short_upper_a: assert property (
		req.valid && (is_add16 || is_sub16)
		|=> (resp_r.data[63:16] == 48'h000000000000))
		else $error("16-bit result upper bits not zero");

	pack_upper_a: assert property (
		req.valid && (is_packh || is_pku || is_pks || is_rtz)
		|=> (resp_r.data[63:32] == 32'h00000000))
		else $error("packed result upper word not zero");

	illegal_code_a: assert property (
		req.valid && !known
		|=> (resp_r.illegal && (resp_r.data == 64'h0000000000000000)))
		else $error("unknown opcode not flagged");

	idle_zero_a: assert property (
		!req.valid
		|=> (!resp_r.illegal && (resp_r.data == 64'h0000000000000000)))
		else $error("idle cycle result not zero");

	upair_clamp_a: assert property (
		req.valid && is_pku && (|req.src0[31:16])
		|=> (resp_r.data[15:0] == vec_misc_pkg::UNORM_MAX))
		else $error("unsigned integer pack did not clamp");

	spair_clamp_a: assert property (
		req.valid && is_pks && !req.src1[31] && (|req.src1[30:15])
		|=> (resp_r.data[31:16] == vec_misc_pkg::S16_MAX))
		else $error("signed integer pack did not clamp high");

	un32_neg_a: assert property (
		req.valid && is_un32 && req.src1[31]
		|=> (resp_r.data[31:16] == 16'h0000))
		else $error("negative single unsigned norm not zero");

	sn16_one_a: assert property (
		req.valid && is_sn16 && (req.src0[15:0] == 16'h3C00)
		|=> (resp_r.data[15:0] == vec_misc_pkg::SNORM_MAX))
		else $error("signed norm of half one is not full scale");

	bfm_offset_a: assert property (
		req.valid && is_bfm
		|=> ((resp_r.data[31:0] & ~(32'hFFFFFFFF << $past(req.src1[4:0]))) == 32'h00000000))
		else $error("bitfield mask has ones below offset");

endmodule : vec_misc_alu

// ### design/vec_misc_pkg.sv
package vec_misc_pkg;

	// ****************************************
	// Opcodes handled by this datapath
	// ****************************************
	localparam int         OP_W      = 10;
	localparam logic [9:0] OP_TRIG   = 10'h292;
	localparam logic [9:0] OP_BFM    = 10'h293;
	localparam logic [9:0] OP_SN32   = 10'h294;
	localparam logic [9:0] OP_UN32   = 10'h295;
	localparam logic [9:0] OP_RTZ    = 10'h296;
	localparam logic [9:0] OP_PKU    = 10'h297;
	localparam logic [9:0] OP_PKS    = 10'h298;
	localparam logic [9:0] OP_SN16   = 10'h299;
	localparam logic [9:0] OP_UN16   = 10'h29A;
	localparam logic [9:0] OP_ADD32  = 10'h29C;
	localparam logic [9:0] OP_SUB32  = 10'h29D;
	localparam logic [9:0] OP_ADD16  = 10'h29E;
	localparam logic [9:0] OP_SUB16  = 10'h29F;
	localparam logic [9:0] OP_PACKH  = 10'h2A0;

	// ****************************************
	// Segment lookup constants
	// ****************************************
	localparam int                 PI_BITS     = 1201;
	localparam int                 SEG_BITS    = 53;
	localparam int                 MAX_SHIFT   = 2613;
	localparam logic        [5:0]  SEG_STRIDE  = 6'h35;
	localparam logic        [10:0] EXP_LIM     = 11'h435;
	localparam logic        [10:0] EXP_BIG     = 11'h7B0;
	localparam logic signed [13:0] SCALE_BASE  = -14'sh0035;
	localparam logic signed [13:0] SCALE_BOOST = 14'sh0080;
	localparam logic signed [13:0] DBL_BIAS    = 14'sh03FF;

	// ****************************************
	// Limits and special encodings
	// ****************************************
	localparam logic [15:0] SNORM_MAX = 16'h7FFF;
	localparam logic [15:0] UNORM_MAX = 16'hFFFF;
	localparam logic [31:0] S32_MAX   = 32'h7FFFFFFF;
	localparam logic [31:0] S32_MIN   = 32'h80000000;
	localparam logic [15:0] S16_MAX   = 16'h7FFF;
	localparam logic [15:0] S16_MIN   = 16'h8000;
	localparam logic [14:0] H_QNAN    = 15'h7E00;
	localparam logic [14:0] H_INF     = 15'h7C00;
	localparam logic [14:0] H_MAXF    = 15'h7BFF;
	localparam logic signed [9:0] H_ADJ = 10'sh070;

	typedef struct packed {
		logic            valid;
		logic            clamp;
		logic [OP_W-1:0] opcode;
		logic [63:0]     src0;
		logic [63:0]     src1;
	} alu_req_s;

	typedef struct packed {
		logic        valid;
		logic        illegal;
		logic [63:0] data;
	} alu_resp_s;

	localparam alu_resp_s RESP_RST = '0;

endpackage : vec_misc_pkg

// ### design/norm16_convert.sv
`timescale 1ns/1ps
module norm16_convert #(
	parameter int EXP_W = 8,
	parameter int MAN_W = 23
) (
	input  wire logic [EXP_W+MAN_W:0] val,   // Float operand
	output logic      [15:0]          snorm, // Signed normalised result
	output logic      [15:0]          unorm  // Unsigned normalised result
);
	localparam int BIAS = 2**(EXP_W-1) - 1;
	localparam int PW   = MAN_W + 17;

	wire             sgn = val[EXP_W+MAN_W];
	wire [EXP_W-1:0] ex  = val[EXP_W+MAN_W-1:MAN_W];
	wire [MAN_W-1:0] fr  = val[MAN_W-1:0];
	wire             nan = (&ex) && (|fr);
	wire             big = (int'(ex) >= BIAS);
	wire [MAN_W:0]   sig = {|ex, fr};
	wire [EXP_W-1:0] ee  = (|ex) ? ex : EXP_W'(1);
	wire [7:0]       sh  = 8'(BIAS + MAN_W - int'(ee));

	// Scale by full range, round to nearest on the last dropped bit
	wire [PW-1:0] ps = PW'(sig) * PW'(vec_misc_pkg::SNORM_MAX);
	wire [PW-1:0] pu = PW'(sig) * PW'(vec_misc_pkg::UNORM_MAX);
	wire [PW-1:0] rs = ps >> (sh - 8'h01);
	wire [PW-1:0] ru = pu >> (sh - 8'h01);
	wire [15:0]   ms = big ? vec_misc_pkg::SNORM_MAX : 16'((rs + PW'(1)) >> 1);
	wire [15:0]   mu = big ? vec_misc_pkg::UNORM_MAX : 16'((ru + PW'(1)) >> 1);

	// Clamp to the unit range; NaN and negative unsigned give zero
	assign snorm = nan ? 16'h0000 : (sgn ? 16'(-ms) : ms);
	assign unorm = (nan || sgn) ? 16'h0000 : mu;

endmodule : norm16_convert

// ### design/two_over_pi_lookup.sv
`timescale 1ns/1ps
module two_over_pi_lookup #(
	parameter logic [vec_misc_pkg::PI_BITS-1:0] TABLE =
		{128'hA2F9836E4E441529FC2757D1F534DDC0, 1073'h0}
) (
	input  wire logic [63:0] src0,   // Double to be reduced
	input  wire logic [4:0]  sel,    // Segment select
	output logic      [63:0] result  // Scaled segment as double
);
	localparam int W = vec_misc_pkg::PI_BITS + vec_misc_pkg::MAX_SHIFT
		+ vec_misc_pkg::SEG_BITS;

	// Bit offset into the constant string
	wire [10:0] exp_in = src0[62:52];
	wire [11:0] excess = (exp_in > vec_misc_pkg::EXP_LIM) ?
		12'(exp_in - vec_misc_pkg::EXP_LIM) : 12'h000;
	wire [11:0] shift  = (12'(sel) * 12'(vec_misc_pkg::SEG_STRIDE)) + excess;

	// Window of 53 bits; bits past the end of the string read as zero
	wire [W-1:0]  ext     = {TABLE, {(W-vec_misc_pkg::PI_BITS){1'b0}}};
	wire [W-1:0]  shifted = ext << shift;
	wire [52:0]   seg     = shifted[W-1 -: 53];

	// Scale exponent, lifted for huge inputs to stay clear of denormals
	wire signed [13:0] scale = vec_misc_pkg::SCALE_BASE - $signed({2'b00, shift})
		+ ((exp_in >= vec_misc_pkg::EXP_BIG) ? vec_misc_pkg::SCALE_BOOST : 14'sh0000);

	logic [5:0] lead;

	// Leading one of the segment
	always_comb begin
		lead = 6'h00;
		for (int i = 0; i < 53; i++) begin
			if (seg[i]) begin
				lead = 6'(i);
			end
		end
	end

	wire [52:0]        man  = seg << (6'd52 - lead);
	wire signed [13:0] be   = $signed({8'h00, lead}) + scale + vec_misc_pkg::DBL_BIAS;
	wire [13:0]        dsh  = 14'(14'sh0001 - be);
	wire [52:0]        dman = (dsh > 14'h0034) ? 53'h0 : (man >> dsh);

	// Exact when normal; denormals truncate toward zero
	assign result = (seg == 53'h0) ? 64'h0 :
		(be >= 14'sh0001) ? {1'b0, be[10:0], man[51:0]} :
		{12'h000, dman[51:0]};

endmodule : two_over_pi_lookup

// ### dv/issue_model.sv
`timescale 1ns/1ps
// ****************************************
// Issue logic stand-in: one instruction per call, no stall
// ****************************************
module issue_model (
	input  wire logic              clock, // Core clock
	output vec_misc_pkg::alu_req_s req    // Instruction handed to the datapath
);
	// Idle bus from time zero so the datapath never samples unknowns
	initial req = '0;

	// Changes the request only just after a rising edge
	task automatic put(input vec_misc_pkg::alu_req_s r);
		@(posedge clock);
		req <= r;
	endtask : put
endmodule : issue_model

// ### dv/vec_misc_alu_tb.sv
`timescale 1ns/1ps
module vec_misc_alu_tb;
	// ****************************************
	// Clock, reset, instances
	// ****************************************
	localparam logic [1215:0] TBL_W = {19{64'hC3A596E10F7B2D48}};
	localparam logic [1200:0] TBL   = TBL_W[1215:15];
	logic                    clock           = 1'b0;
	logic                    rstn            = 1'b0;
	vec_misc_pkg::alu_req_s  req;
	vec_misc_pkg::alu_resp_s resp_r;
	int                      miscompares     = 0;
	int                      samples_checked = 0;
	int                      cycles          = 0;

	// Free-running 200 MHz clock
	always #2.5 clock = ~clock;

	issue_model issuer (.clock(clock), .req(req));
	vec_misc_alu #(.PI_TABLE(TBL)) DUT (.clock(clock), .rstn(rstn), .req(req), .resp_r(resp_r));

	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic chk_data(input logic [63:0] got, input logic [63:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s data %h exp %h", $time, what, got, exp);
		end
	endtask : chk_data

	task automatic chk_flag(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s flag %b exp %b", $time, what, got, exp);
		end
	endtask : chk_flag

	// Result is looked at just after the edge that takes the request
	task automatic expect_ok(input logic [63:0] exp, input string what);
		#1;
		chk_flag(resp_r.valid, 1'b1, what);
		chk_flag(resp_r.illegal, 1'b0, what);
		chk_data(resp_r.data, exp, what);
	endtask : expect_ok

	task automatic run(input logic [9:0] op, input logic cl, input logic [63:0] a,
		input logic [63:0] b, input logic [63:0] exp, input string what);
		issuer.put({1'b1, cl, op, a, b});
		issuer.put('0);
		expect_ok(exp, what);
	endtask : run

	// Expected lookup segment: 53 bits from fraction index s, as an exact double
	function automatic logic [63:0] seg_dbl(input int s, input bit boost);
		logic [1200:0] t;
		logic [52:0]   w;
		int            p;
		t = TBL << s;
		w = t[1200:1148];
		p = -1;
		for (int i = 0; i < 53; i++) begin
			if (w[i]) p = i;
		end
		if (p < 0) return 64'h0;
		w = w << (52 - p);
		return {1'b0, 11'(1023 + p - 53 - s + (boost ? 128 : 0)), w[51:0]};
	endfunction : seg_dbl

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_mask();
		logic [63:0] wd [4] = '{64'h25, 64'h0, 64'h1F, 64'h10};
		logic [63:0] of [4] = '{64'hE4, 64'h3, 64'h0, 64'h10};
		logic [63:0] ex [4] = '{64'h1F0, 64'h0, 64'h7FFFFFFF, 64'hFFFF0000};
		for (int i = 0; i < 4; i++) begin
			run(vec_misc_pkg::OP_BFM, 1'b0, wd[i], of[i], ex[i], "mask");
		end
		$display("test mask done");
	endtask : t_mask

	task automatic t_packs();
		run(vec_misc_pkg::OP_PKU, 1'b0, 64'h12345, 64'h7, 64'h0007FFFF, "upair");
		run(vec_misc_pkg::OP_PKU, 1'b0, 64'hBEEF, 64'h1234, 64'h1234BEEF, "upair in");
		run(vec_misc_pkg::OP_PKS, 1'b0, 64'hFFFF63C0, 64'h10000, 64'h7FFF8000, "spair");
		run(vec_misc_pkg::OP_PACKH, 1'b0, 64'hABCD3C00, 64'h1234C000, 64'hC0003C00, "hpk");
		run(vec_misc_pkg::OP_RTZ, 1'b0, 64'h3F801FFF, 64'hC7800000, 64'hFBFF3C00, "rtz");
		$display("test packs done");
	endtask : t_packs

	task automatic t_norm();
		run(vec_misc_pkg::OP_SN32, 1'b0, 64'h3F800000, 64'hC0000000, 64'h80017FFF, "sn32");
		run(vec_misc_pkg::OP_UN32, 1'b0, 64'h3F000000, 64'hBF800000, 64'h00008000, "un32");
		run(vec_misc_pkg::OP_SN16, 1'b0, 64'h3C00, 64'hBC00, 64'h80017FFF, "sn16");
		run(vec_misc_pkg::OP_UN16, 1'b0, 64'h3800, 64'h7C00, 64'hFFFF8000, "un16");
		run(vec_misc_pkg::OP_UN16, 1'b0, 64'h3C00, 64'hB800, 64'h0000FFFF, "un16n");
		$display("test norm done");
	endtask : t_norm

	task automatic t_sat();
		logic [9:0]  op [4] = '{vec_misc_pkg::OP_ADD32, vec_misc_pkg::OP_SUB32,
			vec_misc_pkg::OP_ADD16, vec_misc_pkg::OP_SUB16};
		logic [63:0] a  [4] = '{64'h7FFFFFFF, 64'h80000000, 64'h7FFF, 64'h8000};
		logic [63:0] st [4] = '{64'h7FFFFFFF, 64'h80000000, 64'h7FFF, 64'h8000};
		logic [63:0] wr [4] = '{64'h80000000, 64'h7FFFFFFF, 64'h8000, 64'h7FFF};
		for (int i = 0; i < 4; i++) begin
			run(op[i], 1'b1, a[i], 64'h1, st[i], "clamped");
			run(op[i], 1'b0, a[i], 64'h1, wr[i], "wrapped");
		end
		$display("test saturate done");
	endtask : t_sat

	// Exponents straddle the excess and the boost thresholds
	task automatic t_lookup();
		logic [10:0] ex [5] = '{11'h3FF, 11'h435, 11'h436, 11'h7AF, 11'h7B0};
		logic [63:0] sl [5] = '{64'h21, 64'h0, 64'h2, 64'h0, 64'h0};
		int          sh [5] = '{53, 0, 107, 890, 891};
		bit          bo [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++) begin
			run(vec_misc_pkg::OP_TRIG, 1'b0, {1'b0, ex[i], 52'h0}, sl[i],
				seg_dbl(sh[i], bo[i]), "lookup");
		end
		$display("test lookup done");
	endtask : t_lookup

	// Two ops on consecutive edges, then unknown codes and an idle cycle
	task automatic t_stream();
		logic [9:0] bad [3] = '{10'h29B, 10'h291, 10'h2A1};
		issuer.put({1'b1, 1'b0, vec_misc_pkg::OP_BFM, 64'h5, 64'h4});
		issuer.put({1'b1, 1'b1, vec_misc_pkg::OP_ADD32, 64'h7FFFFFFF, 64'h1});
		expect_ok(64'h1F0, "first");
		issuer.put('0);
		expect_ok(64'h7FFFFFFF, "second");
		for (int i = 0; i < 3; i++) begin
			issuer.put({1'b1, 1'b0, bad[i], 64'hFFFF, 64'hFFFF});
			issuer.put('0);
			#1;
			chk_flag(resp_r.illegal, 1'b1, "unknown code");
			chk_data(resp_r.data, 64'h0, "unknown code");
		end
		@(posedge clock);
		#1;
		chk_flag(resp_r.valid, 1'b0, "idle");
		chk_data(resp_r.data, 64'h0, "idle");
		$display("test stream done");
	endtask : t_stream

	// ****************************************
	// Verdict, watchdog, main sequence
	// ****************************************
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// Whole run needs about 76 cycles; 3000 leaves ample margin
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			$display("MISMATCH t=%0t watchdog expired", $time);
			give_verdict();
		end
	end

	// Reset for 12 edges, then every scenario in turn
	initial begin
		repeat (11) @(posedge clock);
		#1;
		chk_flag(resp_r.valid, 1'b0, "in reset");
		chk_data(resp_r.data, 64'h0, "in reset");
		@(posedge clock);
		rstn <= 1'b1;
		t_mask();
		t_packs();
		t_norm();
		t_sat();
		t_lookup();
		t_stream();
		give_verdict();
	end
endmodule : vec_misc_alu_tb
